// ---- logic/smc_sleep_ctrl.sv ----
// sleep mode clock gating controller: mode decode, clock enables, wake
// assumes the core pulses sleep_exec for the sleep instruction and that
// wake sources are synchronous, already gated by their interrupt enables
//
// Overview of operation
// - sleep needs arm bit then sleep instruction
// - mode field decodes idle, noise, down, standby
// - idle stops core and memory clocks only
// - idle wakes on any enabled interrupt
// - idle or noise mode starts conversion
// - noise mode keeps converter clock, limited wakes
// - power-down stops all clocks and oscillator
// - deep modes wake on watchdog, level, pin
// - standby keeps oscillator, no start-up delay
// - hold core four cycles after wake
// - register file and memory are preserved
// - reset during sleep restarts at vector
// - gated peripheral frozen, register access blocked
// - ungating peripheral resumes prior state
// - peripheral gating matters in active, idle; converter gating also in noise
// - comparator forced off in power-down
// - converter stays enabled; restart is extended
// - watchdog keeps running in all modes
// - input buffers off in noise, down, standby sleep, except wake pins
// - control register layout and zero reset
// - gate register bits stop converter, timer
// - reserved mode codes enter no mode
`timescale 1ns/1ps
module smc_sleep_ctrl (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [smc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [smc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [smc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic sleep_exec,
    input wire smc_pkg::smc_wake_s wake_src,
    input wire logic wdt_sys_reset,
    input wire logic converter_enabled,
    input wire logic comparator_off,
    input wire logic [3:0] wake_pin_mask,
    output smc_pkg::smc_clk_s clk_en,
    output logic core_halt,
    output logic sleeping,
    output logic conv_start,
    output logic comparator_force_off,
    output logic comparator_off_eff,
    output logic [3:0] digital_input_disable,
    output logic timer_access_ok,
    output logic conv_access_ok,
    output logic [2:0] active_mode
);
    logic [7:0] sleep_control_q;
    logic [7:0] periph_gate_q;
    logic [7:0] rdata_q;
    smc_pkg::smc_state_e state_q;
    logic [2:0] mode_q;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    smc_pkg::smc_state_e state_d;
    logic conv_start_q;
    smc_pkg::smc_clk_s clk_q;

    // field decode
    wire sleep_arm = sleep_control_q[smc_pkg::ARM_BIT];
    wire [2:0] sleep_mode_sel =
        sleep_control_q[smc_pkg::MODE_MSB:smc_pkg::MODE_LSB];
    wire converter_clock_off = periph_gate_q[smc_pkg::CONV_OFF_BIT];
    wire timer_clock_off = periph_gate_q[smc_pkg::TIMER_OFF_BIT];

    // reserved codes fail every compare and are held as no-op
    function automatic logic mode_legal(input logic [2:0] m);
        mode_legal = (m == smc_pkg::MODE_IDLE) ||
            (m == smc_pkg::MODE_NOISE) ||
            (m == smc_pkg::MODE_PDOWN) ||
            (m == smc_pkg::MODE_STANDBY);
    endfunction

    // wake qualification per mode
    function automatic logic wake_ok(input logic [2:0] m,
                                     input smc_pkg::smc_wake_s w);
        logic deep;
        deep = w.wdt_irq || w.ext_zero_level || w.pin_change;
        wake_ok = 1'b0;
        if (m == smc_pkg::MODE_IDLE) begin
            wake_ok = deep || w.ext_zero_edge || w.conv_done ||
                w.other_io || w.monitor_irq;
        end else if (m == smc_pkg::MODE_NOISE) begin
            wake_ok = deep || w.conv_done || w.monitor_irq;
        end else begin
            wake_ok = deep;
        end
    endfunction

    wire sleep_go = sleep_exec && sleep_arm &&
        mode_legal(sleep_mode_sel);
    wire in_sleep = (state_q == smc_pkg::ST_SLEEP);
    wire wake_hit = in_sleep && wake_ok(mode_q, wake_src);
    // power-down restarts the oscillator, standby does not
    wire need_osc = (mode_q == smc_pkg::MODE_PDOWN);
    wire reg_hit_ctrl = (reg_addr == smc_pkg::OFS_SLEEP_CONTROL);
    wire reg_hit_gate = (reg_addr == smc_pkg::OFS_PERIPH_GATE);
    wire reg_hit_stat = (reg_addr == smc_pkg::OFS_STATUS);
    wire [7:0] status_word = {1'b0, mode_q, state_q};

    // registers; a reset in any state clears them and returns to run
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sleep_control_q <= smc_pkg::RST_SLEEP_CONTROL;
            periph_gate_q <= smc_pkg::RST_PERIPH_GATE;
        end else if (reg_wr && reg_hit_ctrl) begin
            sleep_control_q <= {4'h0, reg_wdata[3:0]};
        end else if (reg_wr && reg_hit_gate) begin
            periph_gate_q <= {6'h00, reg_wdata[1:0]};
        end
    end

    // read port: data one cycle after strobe, unmapped reads zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= reg_hit_ctrl ? sleep_control_q :
                reg_hit_gate ? periph_gate_q :
                reg_hit_stat ? status_word : 8'h00;
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // sleep sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            smc_pkg::ST_RUN: begin
                if (sleep_go) begin
                    state_d = smc_pkg::ST_SLEEP;
                end
            end
            smc_pkg::ST_SLEEP: begin
                if (wake_hit && need_osc) begin
                    state_d = smc_pkg::ST_START;
                    cnt_d = smc_pkg::OSC_START_CYCLES - 4'h1;
                end else if (wake_hit) begin
                    state_d = smc_pkg::ST_HALT;
                    cnt_d = {1'b0, smc_pkg::WAKE_HALT_CYCLES} - 4'h1;
                end
            end
            smc_pkg::ST_START: begin
                if (cnt_q == 4'h0) begin
                    state_d = smc_pkg::ST_HALT;
                    cnt_d = {1'b0, smc_pkg::WAKE_HALT_CYCLES} - 4'h1;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            smc_pkg::ST_HALT: begin
                if (cnt_q == 4'h0) begin
                    state_d = smc_pkg::ST_RUN;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
        endcase
    end

    // sequencer state; sys_rst covers reset-in-sleep
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= smc_pkg::ST_RUN;
            cnt_q <= 4'h0;
            mode_q <= smc_pkg::MODE_IDLE;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (sleep_go && state_q == smc_pkg::ST_RUN) begin
                mode_q <= sleep_mode_sel;
            end
        end
    end

    // one-cycle conversion start on entry to idle or noise mode
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= sleep_go && state_q == smc_pkg::ST_RUN &&
                converter_enabled &&
                (sleep_mode_sel == smc_pkg::MODE_IDLE ||
                 sleep_mode_sel == smc_pkg::MODE_NOISE);
        end
    end
    assign conv_start = conv_start_q;

    // clock enables; clocks are gated, never reset, so state survives
    wire m_idle = in_sleep && mode_q == smc_pkg::MODE_IDLE;
    wire m_noise = in_sleep && mode_q == smc_pkg::MODE_NOISE;
    wire m_pdown = in_sleep && mode_q == smc_pkg::MODE_PDOWN;
    wire m_stby = in_sleep && mode_q == smc_pkg::MODE_STANDBY;
    wire run_clk = (state_q == smc_pkg::ST_RUN);
    wire io_run = run_clk || m_idle || state_q == smc_pkg::ST_HALT;
    wire conv_run = io_run || m_noise;
    // the oscillator must run while its start-up is being counted
    wire osc_run = !m_pdown;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            clk_q <= '1;
        end else begin
            clk_q.core_clk_en <= run_clk;
            clk_q.memory_clk_en <= run_clk;
            clk_q.io_clk_en <= io_run;
            clk_q.converter_clk_en <= conv_run;
            clk_q.osc_en <= osc_run;
            clk_q.timer_clk_en <= io_run && !timer_clock_off;
            clk_q.conv_periph_clk_en <=
                conv_run && !converter_clock_off;
        end
    end
    assign clk_en = clk_q;

    // peripheral register access is blocked while its clock is gated
    assign timer_access_ok = !timer_clock_off;
    assign conv_access_ok = !converter_clock_off;
    // comparator is forced off in power-down only
    assign comparator_force_off = m_pdown;
    assign comparator_off_eff = comparator_off || m_pdown;
    // wake pins keep their buffers; watchdog is not gated here
    assign digital_input_disable = (m_noise || m_pdown || m_stby) ?
        ~wake_pin_mask : 4'h0;
    assign core_halt = !run_clk;
    assign sleeping = in_sleep;
    assign active_mode = mode_q;
endmodule

// ---- logic/smc_pkg.sv ----
// package for the sleep mode clock gating controller
// assumes a single system clock and a plain register port
package smc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] OFS_SLEEP_CONTROL = 8'h3a;
    localparam logic [7:0] OFS_PERIPH_GATE = 8'h35;
    localparam logic [7:0] OFS_STATUS = 8'h3b;
    localparam logic [7:0] RST_SLEEP_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPH_GATE = 8'h00;
    localparam int unsigned ARM_BIT = 0;
    localparam int unsigned MODE_LSB = 1;
    localparam int unsigned MODE_MSB = 3;
    localparam int unsigned CONV_OFF_BIT = 1;
    localparam int unsigned TIMER_OFF_BIT = 0;
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NOISE = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_STANDBY = 3'h4;
    // extra halt cycles after wake
    localparam logic [2:0] WAKE_HALT_CYCLES = 3'h4;
    // oscillator start-up after power-down, in main clock cycles
    localparam logic [3:0] OSC_START_CYCLES = 4'h6;

    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_START = 4'b0100,
        ST_HALT = 4'b1000
    } smc_state_e;

    // wake sources from the interrupt, watchdog and monitor logic
    typedef struct packed {
        logic ext_zero_level;
        logic ext_zero_edge;
        logic pin_change;
        logic conv_done;
        logic other_io;
        logic wdt_irq;
        logic monitor_irq;
    } smc_wake_s;

    // clock enables toward the clock tree
    typedef struct packed {
        logic core_clk_en;
        logic memory_clk_en;
        logic io_clk_en;
        logic converter_clk_en;
        logic osc_en;
        logic timer_clk_en;
        logic conv_periph_clk_en;
    } smc_clk_s;
endpackage

// ---- bench/smc_sleep_ctrl_sva.sv ----
// checker for the sleep controller, watching only its ports
// assumes one clock and the synchronous reset of the top module
`timescale 1ns/1ps
module smc_sleep_ctrl_sva (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic sleep_exec,
    input wire smc_pkg::smc_wake_s wake_src,
    input wire logic converter_enabled,
    input wire smc_pkg::smc_clk_s clk_en,
    input wire logic core_halt,
    input wire logic sleeping,
    input wire logic conv_start,
    input wire logic comparator_force_off,
    input wire logic [2:0] active_mode
);
    logic [3:0] ctl_q;
    logic slp_q;
    wire legal = ctl_q[3:1] inside {3'h0, 3'h1, 3'h2, 3'h4};
    wire deep = sleeping && slp_q;
    wire pd = active_mode == smc_pkg::MODE_PDOWN;
    wire sb = active_mode == smc_pkg::MODE_STANDBY;
    // shadow of the control register, so entry can be judged from writes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ctl_q <= 4'h0;
            slp_q <= 1'h0;
        end else begin
            slp_q <= sleeping;
            if (reg_wr && reg_addr == smc_pkg::OFS_SLEEP_CONTROL)
                ctl_q <= reg_wdata[3:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_unarmed_no_sleep: assert property (sleep_exec && !ctl_q[0] |=> !sleeping)
        else $error("sleep entered while disarmed");
    a_armed_entry: assert property (sleep_exec && ctl_q[0] && legal && !core_halt
        |=> sleeping)
        else $error("armed legal sleep not entered");
    a_idle_clocks: assert property (deep && active_mode == smc_pkg::MODE_IDLE
        |-> clk_en[6:2] == 5'h07)
        else $error("idle clock enables wrong");
    a_noise_clocks: assert property (deep && active_mode == smc_pkg::MODE_NOISE
        |-> clk_en[6:2] == 5'h03)
        else $error("noise clock enables wrong");
    a_pdown_clocks: assert property (deep && pd |-> clk_en[6:2] == 5'h00)
        else $error("power-down clock enables wrong");
    a_standby_osc: assert property (deep && sb |-> clk_en[6:2] == 5'h01)
        else $error("standby clock enables wrong");
    a_deep_no_wake: assert property (deep && (pd || sb) && !(wake_src.pin_change
        || wake_src.ext_zero_level || wake_src.wdt_irq) |=> sleeping)
        else $error("deep mode woke on a barred source");
    a_wake_halt: assert property ($fell(sleeping) && !$past(sys_rst) && !pd
        |-> core_halt [*4] ##1 !core_halt)
        else $error("halt after wake not four cycles");
    a_pdown_cmp_off: assert property (deep && pd |-> comparator_force_off)
        else $error("comparator not forced off");
    a_entry_conv: assert property (sleep_exec && ctl_q[0] && !core_halt
        && converter_enabled && ctl_q[3:2] == 2'h0 |-> ##[1:2] conv_start)
        else $error("no conversion at entry");
    c_pdown: cover property (deep && pd);
    c_wake: cover property ($fell(sleeping));
    c_unarmed: cover property (sleep_exec && !ctl_q[0]);
endmodule

bind smc_sleep_ctrl smc_sleep_ctrl_sva u_sva (.clock, .sys_rst, .reg_addr,
    .reg_wdata, .reg_wr, .sleep_exec, .wake_src, .converter_enabled, .clk_en,
    .core_halt, .sleeping, .conv_start, .comparator_force_off, .active_mode);

// ---- bench/smc_core_model.sv ----
// core side model: sleep instruction and held wake sources
// assumes the controller halts the core through core_halt
`timescale 1ns/1ps
module smc_core_model (
    input wire logic clock,
    input wire logic core_halt,
    output logic sleep_exec,
    output smc_pkg::smc_wake_s wake_src
);
    initial begin
        sleep_exec = 1'h0;
        wake_src = '0;
    end
    // the core only issues the instruction while it runs
    task automatic sleep_instr();
        @(posedge clock);
        sleep_exec <= !core_halt;
        @(posedge clock);
        sleep_exec <= 1'h0;
    endtask
    // a level source must stay up until the core runs again
    task automatic raise(input smc_pkg::smc_wake_s w, input int n);
        @(posedge clock);
        wake_src <= w;
        repeat (2) @(posedge clock);
        for (int i = 0; i < n && core_halt; i++) @(posedge clock);
        wake_src <= '0;
    endtask
endmodule

// ---- bench/tb_smc_sleep_ctrl.sv ----
// testbench: registers, every mode, wakes and reset in sleep
// assumes the core model drives the sleep instruction and wake sources
`timescale 1ns/1ps
module tb_smc_sleep_ctrl;
    logic clock = 1'h0, sys_rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic rd_d = 1'h0, converter_enabled = 1'h0, comparator_off = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [3:0] wake_pin_mask = 4'h0;
    logic sleep_exec, core_halt, sleeping, timer_access_ok, conv_access_ok;
    logic [2:0] active_mode;
    logic cmp_eff;
    logic [3:0] did;
    smc_pkg::smc_wake_s wake_src;
    smc_pkg::smc_clk_s clk_en;
    int fail_count = 0, num_checks = 0;
    logic [31:0] seed = 32'hbecf;
    logic [7:0] exp_q[$];
    logic [2:0] md[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    logic [4:0] ck[4] = '{5'h07, 5'h03, 5'h00, 5'h01};
    logic [6:0] wk[4] = '{7'h04, 7'h08, 7'h40, 7'h02};
    logic [6:0] nw[4] = '{7'h00, 7'h04, 7'h2d, 7'h2d};
    smc_sleep_ctrl DUT (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .sleep_exec, .wake_src, .wdt_sys_reset(1'h0),
        .converter_enabled, .comparator_off, .wake_pin_mask, .clk_en,
        .core_halt, .sleeping, .conv_start(), .comparator_force_off(),
        .comparator_off_eff(cmp_eff), .digital_input_disable(did),
        .timer_access_ok,
        .conv_access_ok, .active_mode);
    smc_core_model core (.clock, .core_halt, .sleep_exec, .wake_src);
    always #10 clock = ~clock;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string what, input logic [7:0] e, g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s exp %h got %h", what, e, g);
        end
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clock) begin
        rd_d <= reg_rd;
        if (rd_d) chk("rdata", exp_q.pop_front(), reg_rdata);
    end
    task automatic wr(input logic [7:0] a, d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'h1;
        exp_q.push_back(e);
        @(posedge clock);
        reg_rd <= 1'h0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic sleep_try(input logic [7:0] c);
        wr(8'h3a, c);
        core.sleep_instr();
        repeat (3) @(posedge clock);
    endtask
    initial begin
        logic [31:0] rnd;
        repeat (4) @(posedge clock);
        sys_rst <= 1'h0;
        rd(8'h3a, 8'h00);
        rd(8'h35, 8'h00);
        rd(8'h10, 8'h00);
        wr(8'h3a, 8'hff);
        rd(8'h3a, 8'h0f);
        converter_enabled <= 1'h0;
        wr(8'h35, 8'hff);
        rd(8'h35, 8'h03);
        @(posedge clock);
        chk("access", 8'h00, {timer_access_ok, conv_access_ok});
        wr(8'h35, 8'h00);
        @(posedge clock);
        chk("access", 8'h03, {timer_access_ok, conv_access_ok});
        $display("test registers done");
        sleep_try(8'h04);
        chk("sleeping", 8'h00, sleeping);
        for (int r = 3; r < 8; r += (r == 3) ? 2 : 1) begin
            sleep_try({4'h0, r[2:0], 1'h1});
            chk("sleeping", 8'h00, sleeping);
        end
        $display("test refused entry done");
        for (int k = 0; k < 4; k++) begin
            rnd = xs();
            {converter_enabled, comparator_off, wake_pin_mask} <= rnd[5:0];
            sleep_try({rnd[11:8], md[k], 1'h1});
            chk("mode", md[k], active_mode);
            chk("clk_en", ck[k], clk_en[6:2]);
            chk("sleeping", 8'h01, sleeping);
            chk("cmp_eff", comparator_off | (k == 2), cmp_eff);
            chk("in_dis", (k > 0) ? {4'h0, ~wake_pin_mask} : 8'h00, did);
            if (k > 0) begin
                core.raise(nw[k], 4);
                chk("sleeping", 8'h01, sleeping);
            end
            core.raise(wk[k], 40);
            for (int i = 0; i < 40 && core_halt; i++) @(posedge clock);
            if (core_halt) begin
                fail_count++;
                $display("mismatch wake exp 0 got 1");
                conclude();
            end
            repeat (2) @(posedge clock);
            chk("clk_en", 8'h1f, clk_en[6:2]);
            rd(8'h3b, {1'h0, md[k], 4'h1});
            $display("test mode %0d done", k);
        end
        sleep_try(8'h05);
        sys_rst <= 1'h1;
        @(posedge clock);
        sys_rst <= 1'h0;
        @(posedge clock);
        chk("halt", 8'h00, {sleeping, core_halt});
        rd(8'h3a, 8'h00);
        repeat (3) @(posedge clock);
        $display("test reset in sleep done");
        conclude();
    end
endmodule
